// ### dv/rag_xbar_model.sv
// Purpose: Crossbar stand-in that counts accesses from the generator.
// Assumes: One access per enabled mem_req cycle.
// Notes: Holds no memory contents; the count is enough here.
module rag_xbar_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic mem_req,
   output int acc_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // Each pulse is one indirect access at mem_addr
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) acc_count <= 0;
      else if (mem_req && clk_en) acc_count <= acc_count + 1;
   end
endmodule

// ### dv/relative_address_generator_tb.sv
// Purpose: Self-checking bench for the relative address generator.
// Assumes: Results appear one enabled edge after req.
// Notes: Offsets are unsigned magnitudes; sign comes from the mode.
module relative_address_generator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, clk_en, req, scale, long_ofs, base_unit, index_unit;
   logic dest_unit, mem_write, mem_req, mem_we, upd_en, upd_unit, unit_err;
   logic [3:0] mode;
   logic [1:0] data_size;
   logic [31:0] rel_base, index_reg, mem_addr, upd_value;
   logic [15:0] imm_ofs;
   logic [2:0] dest_address_reg, upd_address_reg;
   int fail_count, comparisons, cycles, acc_count, sent;
   rag_core dut (.clk_sys, .rst, .clk_en, .req, .mode, .data_size, .scale,
      .long_ofs, .rel_base, .base_unit, .index_unit, .index_reg, .imm_ofs,
      .dest_address_reg, .dest_unit, .mem_write, .mem_req, .mem_we,
      .mem_addr, .upd_en, .upd_unit, .upd_address_reg, .upd_value,
      .unit_err);
   rag_xbar_model xbar (.clk_sys, .rst, .clk_en, .mem_req, .acc_count);
   // Compare and count
   task automatic check(string what, logic [31:0] seen, logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Cycle ceiling; the whole run needs well under a hundred cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         stop_test();
      end
   end
   // One request, expectation worked out here; calls run back to back
   task automatic run(logic [3:0] m, logic [1:0] sz, logic sc, logic lg,
      logic [31:0] base, logic [31:0] idx, logic [15:0] imm);
      logic [31:0] op, sum;
      logic post, upd;
      op = lg ? {17'h0, imm[14:0]} : {29'h0, imm[2:0]};
      if (m < 4'h6) op = idx;
      else if (sz == rag_pkg::SIZE_BYTE) op[lg ? 15 : 3] = sc;
      if (sc) op = op << sz;
      sum = m[0] ? base - op : base + op;
      post = m < 4'h2 || m == 4'h6 || m == 4'h7;
      upd = post || m == 4'h4 || m == 4'h5 || m > 4'h9;
      {mode, data_size, scale, long_ofs} = {m, sz, sc, lg};
      {rel_base, index_reg, imm_ofs, req} = {base, idx, imm, 1'b1};
      @(posedge clk_sys);
      #1;
      sent++;
      check("mem_req", mem_req, 1);
      check("mem_we", mem_we, mem_write);
      check("mem_addr", mem_addr, post ? base : sum);
      check("upd_en", upd_en, upd);
      check("unit_err", unit_err, 0);
      if (upd) begin
         check("upd_value", upd_value, sum);
         check("upd_reg", {upd_unit, upd_address_reg},
            {dest_unit, dest_address_reg});
      end
   endtask
   task automatic t_modes();
      for (int i = 0; i < 12; i++) begin
         {dest_unit, mem_write, dest_address_reg} = {i[0], i[1], i[2:0]};
         run(i[3:0], rag_pkg::SIZE_HALF, i[0], 1'b0, 32'h1000, 32'h30,
            16'h5);
      end
   endtask
   // Field edges per size, all scaled; word also unscaled
   task automatic t_ranges();
      run(4'h6, rag_pkg::SIZE_BYTE, 1'b1, 1'b1, 32'h0, 32'h0, 16'h7fff);
      run(4'h9, rag_pkg::SIZE_BYTE, 1'b1, 1'b0, 32'h40, 32'h0, 16'h7);
      run(4'h8, rag_pkg::SIZE_BYTE, 1'b1, 1'b0, 32'h40, 32'h0, 16'h7);
      run(4'h7, rag_pkg::SIZE_HALF, 1'b1, 1'b1, 32'h20000, 32'h0, 16'h7fff);
      run(4'h8, rag_pkg::SIZE_WORD, 1'b1, 1'b1, 32'h4, 32'h0, 16'h7fff);
      run(4'hb, rag_pkg::SIZE_WORD, 1'b1, 1'b0, 32'h100, 32'h0, 16'h7);
      run(4'h8, rag_pkg::SIZE_WORD, 1'b0, 1'b0, 32'h100, 32'h0, 16'h7);
   endtask
   // Index from the other unit is refused; offsets do not care
   task automatic t_refuse();
      index_unit = 1'b1;
      mode = 4'h2;
      @(posedge clk_sys);
      #1;
      check("mem_req", mem_req, 0);
      check("unit_err", unit_err, 1);
      mode = 4'hc;
      @(posedge clk_sys);
      #1;
      check("mem_req", mem_req, 0);
      check("upd_en", upd_en, 0);
      check("unit_err", unit_err, 0);
      run(4'ha, rag_pkg::SIZE_WORD, 1'b0, 1'b0, 32'h40, 32'h0, 16'h3);
      index_unit = 1'b0;
   endtask
   // Stalled and idle cycles make no access
   task automatic t_idle();
      clk_en = 1'b0;
      @(posedge clk_sys);
      #1;
      check("mem_req", mem_req, 1);
      check("mem_addr", mem_addr, 32'h43);
      req = 1'b0;
      clk_en = 1'b1;
      @(posedge clk_sys);
      #1;
      check("mem_req", mem_req, 0);
      check("acc_count", acc_count, sent);
   endtask
   // Reset in mid-run clears outputs; a request right after is served
   task automatic t_reset();
      run(4'h0, rag_pkg::SIZE_WORD, 1'b0, 1'b0, 32'h80, 32'h4, 16'h0);
      rst = 1'b1;
      #1;
      check("mem_req", mem_req, 0);
      check("upd_en", upd_en, 0);
      check("mem_addr", mem_addr, 0);
      check("upd_value", upd_value, 0);
      @(posedge clk_sys);
      #1;
      rst = 1'b0;
      @(posedge clk_sys);
      #1;
      check("mem_req", mem_req, 1);
      check("mem_addr", mem_addr, 32'h80);
      check("upd_value", upd_value, 32'h84);
      req = 1'b0;
   endtask
   initial begin
      {rst, clk_en, req, mode, data_size, scale, long_ofs} = 11'h400;
      {rel_base, index_reg, imm_ofs, base_unit, index_unit} = '0;
      {dest_address_reg, dest_unit, mem_write} = '0;
      repeat (3) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      clk_en = 1'b1;
      t_modes();
      t_ranges();
      t_refuse();
      t_idle();
      t_reset();
      stop_test();
   end
endmodule

// ### logic/rag_core.sv
// Purpose: Base-relative address generation with register write-back.
// Assumes: Decoder holds operands stable while req is high.
// Notes: One request per cycle; results registered, one cycle latency.
module rag_core #(
   parameter int ADDR_W = rag_pkg::ADDR_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic req,
   input wire logic [3:0] mode,
   input wire logic [1:0] data_size,
   input wire logic scale,
   input wire logic long_ofs,
   input wire logic [ADDR_W-1:0] rel_base,
   input wire logic base_unit,
   input wire logic index_unit,
   input wire logic [ADDR_W-1:0] index_reg,
   input wire logic [15:0] imm_ofs,
   input wire logic [2:0] dest_address_reg,
   input wire logic dest_unit,
   input wire logic mem_write,
   output logic mem_req,
   output logic mem_we,
   output logic [ADDR_W-1:0] mem_addr,
   output logic upd_en,
   output logic upd_unit,
   output logic [2:0] upd_address_reg,
   output logic [ADDR_W-1:0] upd_value,
   output logic unit_err
);
   // A scaled long word offset needs 17 bits plus a carry into the base
   if (ADDR_W < 18) begin : g_bad_width
      $error("rag_core: ADDR_W too small for long offsets");
   end

   logic is_ofs, is_sub, is_post, is_upd, unit_ok, mode_ok;
   logic [ADDR_W-1:0] ofs_raw, ofs_scaled, sum, acc_addr;
   logic next_mem_req, next_mem_we, next_upd_en, next_unit_err;
   logic next_upd_unit;
   logic [2:0] next_upd_reg;
   logic [ADDR_W-1:0] next_mem_addr, next_upd_value;
   rag_pkg::rag_mode_t m;

   // Decode the form into offset source, sign, post and update flags
   always_comb begin
      m = rag_pkg::rag_mode_t'(mode);
      mode_ok = (mode < 4'(rag_pkg::NUM_MODES));
      is_ofs = (mode >= 4'(rag_pkg::RAG_POST_ADD_OFS));
      is_sub = 1'b0;
      is_post = 1'b0;
      is_upd = 1'b0;
      case (m)
         rag_pkg::RAG_POST_ADD_IDX, rag_pkg::RAG_POST_ADD_OFS: begin
            is_post = 1'b1;
            is_upd = 1'b1;
         end
         rag_pkg::RAG_POST_SUB_IDX, rag_pkg::RAG_POST_SUB_OFS: begin
            is_post = 1'b1;
            is_upd = 1'b1;
            is_sub = 1'b1;
         end
         rag_pkg::RAG_PRE_SUB_IDX, rag_pkg::RAG_PRE_SUB_OFS: begin
            is_sub = 1'b1;
         end
         rag_pkg::RAG_PRE_ADD_IDX_UPD, rag_pkg::RAG_PRE_ADD_OFS_UPD: begin
            is_upd = 1'b1;
         end
         rag_pkg::RAG_PRE_SUB_IDX_UPD, rag_pkg::RAG_PRE_SUB_OFS_UPD: begin
            is_upd = 1'b1;
            is_sub = 1'b1;
         end
         default: begin
            is_upd = 1'b0;
         end
      endcase
   end

   // Immediate offset; byte data borrows the scale bit as top bit
   always_comb begin
      if (long_ofs) begin
         if (data_size == rag_pkg::SIZE_BYTE)
            ofs_raw = ADDR_W'({scale, imm_ofs[14:0]});
         else
            ofs_raw = ADDR_W'(imm_ofs[14:0]);
      end else begin
         if (data_size == rag_pkg::SIZE_BYTE)
            ofs_raw = ADDR_W'({scale, imm_ofs[2:0]});
         else
            ofs_raw = ADDR_W'(imm_ofs[2:0]);
      end
   end

   // Scale by data size; a shift keeps results size multiples
   always_comb begin
      acc_addr = is_ofs ? ofs_raw : index_reg;
      ofs_scaled = acc_addr;
      if (scale && data_size == rag_pkg::SIZE_HALF)
         ofs_scaled = acc_addr << rag_pkg::SHIFT_HALF;
      else if (scale && data_size == rag_pkg::SIZE_WORD)
         ofs_scaled = acc_addr << rag_pkg::SHIFT_WORD;
      sum = is_sub ? rel_base - ofs_scaled : rel_base + ofs_scaled;
   end

   // Index must come from the base's unit; offsets need no check
   assign unit_ok = is_ofs || (index_unit == base_unit);

   // Next outputs: post forms access the base, pre forms the sum
   always_comb begin
      next_mem_req = req && unit_ok && mode_ok;
      next_mem_we = req && mem_write;
      next_mem_addr = is_post ? rel_base : sum;
      next_upd_en = next_mem_req && is_upd;
      next_upd_unit = dest_unit;
      next_upd_reg = dest_address_reg;
      next_upd_value = sum;
      next_unit_err = req && !unit_ok;
   end

   // Single stage so the update is seen by the next instruction
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= '0;
         upd_en <= 1'b0;
         upd_unit <= 1'b0;
         upd_address_reg <= 3'h0;
         upd_value <= '0;
         unit_err <= 1'b0;
      end else if (clk_en) begin
         mem_req <= next_mem_req;
         mem_we <= next_mem_we && next_mem_req;
         mem_addr <= next_mem_addr;
         upd_en <= next_upd_en;
         upd_unit <= next_upd_unit;
         upd_address_reg <= next_upd_reg;
         upd_value <= next_upd_value;
         unit_err <= next_unit_err;
      end
   end

   // Assertions check outputs one enabled cycle after request
   sequence s_post_req;
      req && clk_en && unit_ok && mode_ok && is_post;
   endsequence

   chk_post_access: assert property (@(posedge clk_sys) disable iff (rst)
      s_post_req |=> mem_addr == $past(rel_base))
      else $error("post form did not access base");
   chk_post_upd: assert property (@(posedge clk_sys) disable iff (rst)
      s_post_req |=> upd_en)
      else $error("post form missed update");
   chk_pre_noupd: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && (m == rag_pkg::RAG_PRE_ADD_IDX ||
       m == rag_pkg::RAG_PRE_SUB_OFS)) |=> !upd_en)
      else $error("plain pre form updated register");
   chk_pre_addr: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && mode_ok && unit_ok && !is_post)
      |=> mem_addr == upd_value)
      else $error("pre form address differs from sum");
   chk_unit_block: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && !is_ofs && index_unit != base_unit)
      |=> !mem_req && unit_err)
      else $error("foreign index register accepted");
   chk_word_align: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && is_ofs && scale && !is_post &&
       data_size == rag_pkg::SIZE_WORD)
      |=> mem_addr[1:0] == $past(rel_base[1:0]))
      else $error("word scaled offset not multiple of four");
   chk_half_align: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && is_ofs && scale && !is_post &&
       data_size == rag_pkg::SIZE_HALF)
      |=> mem_addr[0] == $past(rel_base[0]))
      else $error("halfword scaled offset odd");
   chk_dest_reg: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en) |=> upd_address_reg == $past(dest_address_reg))
      else $error("update register mismatch");
   chk_byte_ext: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && is_ofs && !is_sub && !is_post && !long_ofs &&
       data_size == rag_pkg::SIZE_BYTE && scale)
      |=> mem_addr == $past(rel_base) + ADDR_W'(8 + $past(imm_ofs[2:0])))
      else $error("byte short offset lacks extra bit");

   // Forms outside the twelve are dropped without any side effect
   chk_mode_refuse: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && !mode_ok) |=> !mem_req && !upd_en)
      else $error("undefined form was accepted");

   // A low enable must freeze the results the crossbar is looking at
   chk_freeze_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !clk_en |=> $stable(mem_req) && $stable(mem_addr))
      else $error("outputs moved while clock enable low");

   // Unscaled post index forms: register gets base plus or minus index
   sequence s_post_add_idx;
      req && clk_en && unit_ok && !scale &&
      m == rag_pkg::RAG_POST_ADD_IDX;
   endsequence
   sequence s_post_sub_idx;
      req && clk_en && unit_ok && !scale &&
      m == rag_pkg::RAG_POST_SUB_IDX;
   endsequence

   chk_post_add_val: assert property (@(posedge clk_sys) disable iff (rst)
      s_post_add_idx |=> upd_value == $past(rel_base) + $past(index_reg))
      else $error("post add index wrote wrong value");
   chk_post_sub_val: assert property (@(posedge clk_sys) disable iff (rst)
      s_post_sub_idx |=> upd_value == $past(rel_base) - $past(index_reg))
      else $error("post subtract index wrote wrong value");

   // A refused index never reaches the crossbar in the same cycle
   chk_err_no_acc: assert property (@(posedge clk_sys) disable iff (rst)
      unit_err |-> !mem_req)
      else $error("refused request still made an access");

   // Updates and stores only ride on an accepted access
   chk_upd_with_acc: assert property (@(posedge clk_sys) disable iff (rst)
      upd_en |-> mem_req)
      else $error("update without access");
   chk_we_with_acc: assert property (@(posedge clk_sys) disable iff (rst)
      mem_we |-> mem_req)
      else $error("store strobe without access");

   // Long scaled word offset is the field times four
   chk_long_word: assert property (@(posedge clk_sys) disable iff (rst)
      (req && clk_en && scale && long_ofs &&
       m == rag_pkg::RAG_PRE_ADD_OFS && data_size == rag_pkg::SIZE_WORD)
      |=> mem_addr == $past(rel_base) +
         (ADDR_W'($past(imm_ofs[14:0])) << 2))
      else $error("long word offset not scaled by four");
endmodule

// ### logic/rag_pkg.sv
// Purpose: Constants and types for the relative address generator.
// Assumes: 32-bit addresses, eight address and eight index registers.
// Notes: Mode codes are internal to this block.
//
// Functional notes
// - Post index add: access base, reg gets base+index
// - Post index subtract: access base, reg gets base-index
// - Pre index: access base+-index, update optional
// - Post offset: access base, reg gets base+-offset
// - Pre offset: access base+-offset, update optional
// - Index register from base's own unit
// - Any address register may receive update
// - Offsets are instruction immediates, not registers
// - Every computed address drives a memory access (code: a refused index or a form outside the twelve leaves mem_req low)
// - Byte size: scale bit extends offset field
// - Scaled offset is multiple of data size
// - Halfword scaled offsets are even
// - Word scaled offsets are multiples of four
// - Scaling multiplies index or offset by size
// - Both units share twelve modes, scaled variants
package rag_pkg;
   localparam int ADDR_W = 32;
   localparam int REG_SEL_W = 3;
   localparam int UNIT_W = 1;
   localparam int SHORT_OFS_W = 3;
   localparam int LONG_OFS_W = 15;
   localparam int MODE_W = 4;
   localparam int SIZE_W = 2;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SHIFT_HALF = 2'h1;
   localparam logic [1:0] SHIFT_WORD = 2'h2;
   localparam int NUM_MODES = 12;
   // Twelve addressing forms
   typedef enum logic [3:0] {
      RAG_POST_ADD_IDX, RAG_POST_SUB_IDX,
      RAG_PRE_ADD_IDX, RAG_PRE_SUB_IDX,
      RAG_PRE_ADD_IDX_UPD, RAG_PRE_SUB_IDX_UPD,
      RAG_POST_ADD_OFS, RAG_POST_SUB_OFS,
      RAG_PRE_ADD_OFS, RAG_PRE_SUB_OFS,
      RAG_PRE_ADD_OFS_UPD, RAG_PRE_SUB_OFS_UPD
   } rag_mode_t;
endpackage
